// ==== bench/seg_table_model.sv ====
// Segment table memory model answering the guard's entry fetches
module seg_table_model #(
  parameter logic [15:0] BASE = 16'h2000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tbl_req_i,
  input wire logic [15:0] tbl_addr_i,
  output logic [71:0] tbl_data_o,
  output logic tbl_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import guard_pkg::*;
  logic busy_reg;
  logic [1:0] wait_reg;
  logic [15:0] addr_reg;
  // Entry 0 code and data, entry 1 disabled, entry 2 data only over firmware RAM
  function automatic seg_entry_type entry(input logic [15:0] idx);
    case (idx)
      16'h0000: return '{1'b1, 1'b1, 16'h0008, 16'h1000, 16'h10ff, 16'h7000};
      16'h0001: return '{1'b0, 1'b0, 16'h0000, 16'h2000, 16'h20ff, 16'h0000};
      16'h0002: return '{1'b1, 1'b0, 16'h0000, 16'h3000, 16'h31ff, 16'h9000};
      default: return '0;
    endcase
  endfunction : entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      addr_reg <= 16'h0000;
      tbl_valid_o <= 1'b0;
      tbl_data_o <= '0;
    end else begin
      tbl_valid_o <= 1'b0;
      // Released data toggles so a stale word never looks valid
      tbl_data_o <= ~tbl_data_o;
      if (busy_reg) begin
        if (wait_reg == 2'h0) begin
          tbl_valid_o <= 1'b1;
          tbl_data_o <= {6'h00, entry(addr_reg - BASE)};
          busy_reg <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end else if (tbl_req_i) begin
        busy_reg <= 1'b1;
        addr_reg <= tbl_addr_i;
        // Odd entries answer slowly, even ones promptly
        wait_reg <= tbl_addr_i[0] ? 2'h3 : 2'h0;
      end
    end
  end
endmodule : seg_table_model

// ==== bench/tb_mode_based_memory_access_guard.sv ====
// Self-checking bench for the mode based memory access guard
module tb_mode_based_memory_access_guard;
  timeunit 1ns;
  timeprecision 1ps;
  import guard_pkg::*;
  typedef struct packed {
    logic ok;
    logic pchk;
    logic [15:0] pa;
    logic wr;
    logic [7:0] wd;
    logic rchk;
  } exp_type;
  logic clk, rstn, copy_cfg, req_ready, fault, tbl_req, tbl_valid;
  acc_req_type req;
  tgt_type tgt;
  mode_type mode;
  logic [7:0] rdata;
  logic [15:0] tbl_addr, a;
  logic [71:0] tbl_data;
  logic [7:0] fw_val [6] = '{8'h08, 8'h00, 8'h00, 8'hc1, 8'h10, 8'h00};
  exp_type q[$];
  exp_type e;
  int error_cnt, checks, cycles, tbl_n;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  mode_based_memory_access_guard mode_based_memory_access_guard_inst (
    .CLK_I(clk), .RSTN_I(rstn), .REQ_I(req), .REQ_READY_O(req_ready), .COPY_CFG_I(copy_cfg),
    .TGT_O(tgt), .FAULT_O(fault), .RDATA_O(rdata), .MODE_O(mode), .TBL_REQ_O(tbl_req),
    .TBL_ADDR_O(tbl_addr), .TBL_DATA_I(tbl_data), .TBL_VALID_I(tbl_valid));
  seg_table_model seg_table_model_inst (
    .clk_i(clk), .rstn_i(rstn), .tbl_req_i(tbl_req), .tbl_addr_i(tbl_addr),
    .tbl_data_o(tbl_data), .tbl_valid_o(tbl_valid));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR at %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // Request held until the edge where ready is high; valid stays up for back to back use
  task automatic acc(input kind_type k, input logic s, input logic c, input sfr_group_type g,
      input logic [15:0] ad, input logic [7:0] d, input logic ok, input logic [15:0] pa);
    q.push_back('{ok, !s, pa, k == ACC_WRITE, d, s && g == GRP_CPU_GEN && k == ACC_READ && ok});
    req <= '{1'b1, k, s, c, g, ad, d};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
  endtask : acc
  task automatic mem(input kind_type k, input logic [15:0] ad, input logic ok,
      input logic [15:0] pa);
    acc(k, 1'b0, 1'b0, GRP_SEG_CFG, ad, 8'($urandom), ok, pa);
  endtask : mem
  task automatic sfr(input kind_type k, input sfr_group_type g, input logic [3:0] i,
      input logic [7:0] d, input logic ok);
    acc(k, 1'b1, 1'b0, g, {12'h000, i}, d, ok, 16'h0000);
  endtask : sfr
  task automatic idle(input int n);
    req.valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic set_mode(input logic [7:0] d, input mode_type want);
    sfr(ACC_WRITE, GRP_SYS_MGMT, IDX_MODE, d, 1'b1);
    idle(2);
    chk(mode, want);
  endtask : set_mode
  // Answers are matched in order against the oldest note
  always @(negedge clk) begin
    if (rstn && (tgt.valid === 1'b1 || fault === 1'b1)) begin
      chk(tgt.valid ^ fault, 1);
      chk(q.size() > 0, 1);
      if (q.size() > 0) begin
        e = q.pop_front();
        chk(fault, !e.ok);
        if (e.ok && e.pchk) chk(tgt.paddr, e.pa);
        if (e.ok) chk(tgt.write, e.wr);
        if (e.ok) chk(tgt.is_sfr, !e.pchk);
        if (e.ok && e.wr) chk(tgt.wdata, e.wd);
        if (e.rchk) chk(rdata, e.wd);
      end
    end
    if (rstn && tbl_req === 1'b1) begin
      chk(tbl_addr, 16'h2000 + 16'(tbl_n));
      tbl_n++;
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    rstn = 1'b0;
    copy_cfg = 1'b0;
    req = '0;
    error_cnt = 0;
    checks = 0;
    tbl_n = 0;
    void'($urandom(32'h5248));
    repeat (5) @(posedge clk);
    chk(mode, MODE_BOOT);
    chk({req_ready, fault, tgt}, {1'b1, 1'b0, 27'h0});
    rstn <= 1'b1;
    mem(ACC_READ, 16'h0100, 1'b1, 16'h0100);
    sfr(ACC_WRITE, GRP_CPU_GEN, 4'h0, 8'h5a, 1'b1);
    sfr(ACC_READ, GRP_CPU_GEN, 4'h0, 8'h5a, 1'b1);
    for (int i = 0; i < 6; i++) sfr(ACC_WRITE, GRP_FW_WALL, 4'(i), fw_val[i], 1'b1);
    sfr(ACC_WRITE, GRP_SEG_CFG, IDX_PTR_LOW, 8'h00, 1'b1);
    sfr(ACC_WRITE, GRP_SEG_CFG, IDX_PTR_HIGH, 8'h20, 1'b1);
    sfr(ACC_WRITE, GRP_SEG_CFG, IDX_SEG_NUM, 8'h03, 1'b1);
    set_mode(8'(MODE_TEST), MODE_TEST);
    mem(ACC_READ, 16'h0100, 1'b1, 16'h0100);
    sfr(ACC_READ, GRP_TEST, 4'h0, 8'h00, 1'b1);
    set_mode(8'(MODE_FW), MODE_FW);
    mem(ACC_READ, 16'h0100, 1'b0, 16'h0000);
    mem(ACC_READ, 16'hc000, 1'b1, 16'hc000);
    sfr(ACC_READ, GRP_HW_COMP, 4'h3, 8'h00, 1'b1);
    sfr(ACC_READ, GRP_HW_COMP, 4'h4, 8'h00, 1'b0);
    sfr(ACC_WRITE, GRP_FW_WALL, 4'h0, 8'hff, 1'b0);
    sfr(ACC_READ, GRP_FW_WALL, 4'h0, 8'h00, 1'b1);
    sfr(ACC_READ, GRP_TEST, 4'h0, 8'h00, 1'b0);
    set_mode(8'(MODE_SYS), MODE_SYS);
    set_mode(8'h07, MODE_SYS);
    mem(ACC_FETCH, 16'h1010, 1'b1, 16'h8010);
    for (int i = 0; i < 8; i++) begin
      a = 16'h1000 + 16'($urandom_range(255));
      mem(i[0] ? ACC_WRITE : ACC_READ, a, 1'b1, a + 16'h7000);
    end
    mem(ACC_WRITE, 16'h10ff, 1'b1, 16'h80ff);
    mem(ACC_READ, 16'h1100, 1'b0, 16'h0000);
    mem(ACC_READ, 16'h2010, 1'b0, 16'h0000);
    mem(ACC_READ, 16'h3000, 1'b0, 16'h0000);
    mem(ACC_WRITE, 16'h3105, 1'b1, 16'hc105);
    mem(ACC_WRITE, 16'h3110, 1'b0, 16'h0000);
    mem(ACC_FETCH, 16'h3105, 1'b0, 16'h0000);
    sfr(ACC_READ, GRP_HW_COMP, 4'h3, 8'h00, 1'b1);
    sfr(ACC_READ, GRP_HW_COMP, 4'h4, 8'h00, 1'b0);
    sfr(ACC_READ, GRP_SEG_CFG, IDX_PTR_LOW, 8'h00, 1'b1);
    idle(1);
    copy_cfg <= 1'b1;
    @(posedge clk);
    copy_cfg <= 1'b0;
    set_mode(8'(MODE_USER), MODE_USER);
    sfr(ACC_WRITE, GRP_CPU_GEN, 4'h0, 8'ha5, 1'b1);
    sfr(ACC_READ, GRP_CPU_GEN, 4'h0, 8'ha5, 1'b1);
    sfr(ACC_WRITE, GRP_SEG_CFG, IDX_PTR_LOW, 8'h00, 1'b0);
    sfr(ACC_WRITE, GRP_SYS_MGMT, IDX_MODE, 8'(MODE_SYS), 1'b0);
    sfr(ACC_READ, GRP_HW_COMP, 4'h4, 8'h00, 1'b0);
    chk(mode, MODE_USER);
    sfr(ACC_READ, GRP_TEST, 4'h0, 8'h00, 1'b0);
    acc(ACC_READ, 1'b1, 1'b1, GRP_CPU_GEN, 16'h0000, 8'h5a, 1'b1, 16'h0000);
    acc(ACC_WRITE, 1'b0, 1'b1, GRP_SEG_CFG, 16'h1020, 8'h3c, 1'b1, 16'h8020);
    acc(ACC_WRITE, 1'b1, 1'b1, GRP_SYS_MGMT, 16'h0000, 8'(MODE_USER), 1'b1, 16'h0000);
    idle(3);
    chk(q.size(), 0);
    chk(tbl_n, 3);
    results();
  end
endmodule : tb_mode_based_memory_access_guard

// ==== verilog/guard_pkg.sv ====
// Shared types and constants for the memory access guard
package guard_pkg;
  typedef enum logic [2:0] {
    MODE_BOOT = 3'h0,
    MODE_TEST = 3'h1,
    MODE_FW = 3'h2,
    MODE_SYS = 3'h3,
    MODE_USER = 3'h4
  } mode_type;
  typedef enum logic [1:0] {
    ACC_READ = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_FETCH = 2'h2
  } kind_type;
  typedef enum logic [2:0] {
    GRP_SEG_CFG = 3'h0,
    GRP_SYS_MGMT = 3'h1,
    GRP_FW_WALL = 3'h2,
    GRP_FW_INT = 3'h3,
    GRP_TEST = 3'h4,
    GRP_HW_COMP = 3'h5,
    GRP_CPU_GEN = 3'h6
  } sfr_group_type;
  localparam int SEG_COUNT = 64;
  localparam int SEG_W = 6;
  localparam int ADDR_W = 16;
  localparam int COMP_W = 4;
  localparam int TBL_DATA_W = 72;
  typedef struct packed {
    logic rw;
    logic ex;
    logic [15:0] sfr_perm;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
    logic [ADDR_W-1:0] reloc;
  } seg_entry_type;
  typedef struct packed {
    logic valid;
    kind_type kind;
    logic is_sfr;
    logic copier;
    sfr_group_type group;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } acc_req_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic is_sfr;
    logic [ADDR_W-1:0] paddr;
    logic [7:0] wdata;
  } tgt_type;
  // Physical map
  localparam logic [ADDR_W-1:0] TEST_ROM_LAST = 16'h0fff;
  localparam logic [ADDR_W-1:0] FW_EE_FIRST = 16'h4000;
  localparam logic [ADDR_W-1:0] FW_EE_LAST = 16'h4fff;
  localparam logic [ADDR_W-1:0] FW_RAM_FIRST = 16'hc000;
  localparam logic [ADDR_W-1:0] FW_RAM_LAST = 16'hc3ff;
  // SFR index within a group
  localparam logic [3:0] IDX_PTR_LOW = 4'h0;
  localparam logic [3:0] IDX_PTR_HIGH = 4'h1;
  localparam logic [3:0] IDX_SEG_NUM = 4'h2;
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_FW_CTRL_LOW = 4'h0;
  localparam logic [3:0] IDX_FW_CTRL_HIGH = 4'h1;
  localparam logic [3:0] IDX_XBASE_LOW = 4'h2;
  localparam logic [3:0] IDX_XBASE_HIGH = 4'h3;
  localparam logic [3:0] IDX_XSIZE_LOW = 4'h4;
  localparam logic [3:0] IDX_XSIZE_HIGH = 4'h5;
endpackage : guard_pkg

// ==== verilog/mode_based_memory_access_guard.sv ====
// Mode and segment based access guard between CPU, copier and memories
// Overview of operation
// - Five modes, one active, tags every access
// - Entry: rights, first, last, relocation; 64 entries
// - Entry also holds peripheral register rights
// - Entry without rights is disabled
// - Any segment count up to 64 works
// - Read and write share one right
// - CPU registers banked for system and user
// - Firewall mask and exchange window registers
// - Peripheral access denied unless granted
// - Register access by group and mode
// - Copier checked with configuring software's rights
// - Table fetched from memory via pointer
// - Application addresses translated to physical
// - Firmware memory hidden from applications outside the exchange window
// - Check completes before memory is touched
module mode_based_memory_access_guard (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire guard_pkg::acc_req_type REQ_I,
  output logic REQ_READY_O,
  input wire logic COPY_CFG_I,
  output guard_pkg::tgt_type TGT_O,
  output logic FAULT_O,
  output logic [7:0] RDATA_O,
  output guard_pkg::mode_type MODE_O,
  output logic TBL_REQ_O,
  output logic [guard_pkg::ADDR_W-1:0] TBL_ADDR_O,
  input wire logic [guard_pkg::TBL_DATA_W-1:0] TBL_DATA_I,
  input wire logic TBL_VALID_I
);
  import guard_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_WAIT = 3'b100
  } fill_state_type;
  fill_state_type state_reg;
  seg_entry_type seg_table [SEG_COUNT];
  mode_type mode_reg;
  mode_type copy_mode_reg;
  logic [SEG_W-1:0] exec_seg_reg;
  logic [SEG_W-1:0] copy_seg_reg;
  logic [ADDR_W-1:0] tbl_ptr_reg;
  logic [SEG_W:0] seg_num_reg;
  logic [SEG_W:0] fill_idx_reg;
  logic [15:0] fw_ctrl_reg;
  logic [15:0] xbase_reg;
  logic [15:0] xsize_reg;
  logic [7:0] bank_reg [2][4];
  logic [SEG_COUNT-1:0] hit_vec;
  logic [SEG_COUNT-1:0] ok_vec;
  logic [ADDR_W-1:0] paddr_vec [SEG_COUNT];
  logic taken;
  mode_type mode_eff;
  logic [SEG_W-1:0] seg_eff;
  logic xlate;
  logic seg_hit;
  logic [SEG_W-1:0] seg_idx;
  logic allowed;
  logic [ADDR_W-1:0] paddr;
  logic in_fw;
  logic in_xwin;
  logic sfr_wr;
  logic [3:0] idx;
  logic refresh_go;
  logic mode_wr;

  assign REQ_READY_O = state_reg == ST_IDLE;
  assign taken = REQ_I.valid && REQ_READY_O;
  assign MODE_O = mode_reg;
  assign idx = REQ_I.addr[3:0];
  // Copier runs with the mode and code segment captured at setup
  assign mode_eff = REQ_I.copier ? copy_mode_reg : mode_reg;
  assign seg_eff = REQ_I.copier ? copy_seg_reg : exec_seg_reg;
  assign xlate = !REQ_I.is_sfr && (mode_eff == MODE_SYS || mode_eff == MODE_USER);

  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++) begin : gen_seg
      segment_match segment_match_inst (
        .entry_i(seg_table[g]),
        .vaddr_i(REQ_I.addr),
        .fetch_i(REQ_I.kind == ACC_FETCH),
        .hit_o(hit_vec[g]),
        .ok_o(ok_vec[g]),
        .paddr_o(paddr_vec[g])
      );
    end
  endgenerate

  // Lowest matching entry wins when segments overlap
  always_comb begin
    seg_hit = 1'b0;
    seg_idx = '0;
    for (int i = SEG_COUNT - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        seg_hit = 1'b1;
        seg_idx = SEG_W'(i);
      end
    end
  end

  assign paddr = xlate ? paddr_vec[seg_idx] : REQ_I.addr;
  assign in_fw = (paddr >= FW_EE_FIRST && paddr <= FW_EE_LAST) ||
                 (paddr >= FW_RAM_FIRST && paddr <= FW_RAM_LAST);
  assign in_xwin = paddr >= xbase_reg && paddr - xbase_reg < xsize_reg;

  // Decision is combinational on the request; target only sees it next edge
  always_comb begin
    allowed = 1'b0;
    if (REQ_I.is_sfr) begin
      unique case (REQ_I.group)
        GRP_SEG_CFG, GRP_SYS_MGMT: allowed = mode_eff != MODE_USER;
        GRP_FW_WALL: allowed = mode_eff == MODE_BOOT ||
                               (mode_eff == MODE_FW && REQ_I.kind == ACC_READ);
        GRP_FW_INT: allowed = mode_eff == MODE_BOOT || mode_eff == MODE_FW;
        GRP_TEST: allowed = mode_eff == MODE_BOOT || mode_eff == MODE_TEST;
        GRP_HW_COMP: begin
          unique case (mode_eff)
            MODE_BOOT, MODE_TEST: allowed = 1'b1;
            MODE_FW: allowed = fw_ctrl_reg[REQ_I.addr[COMP_W-1:0]];
            default: allowed = seg_table[seg_eff].sfr_perm[REQ_I.addr[COMP_W-1:0]];
          endcase
        end
        GRP_CPU_GEN: allowed = 1'b1;
        default: allowed = 1'b0;
      endcase
    end else if (xlate) begin
      allowed = seg_hit && ok_vec[seg_idx];
      if (in_fw && !in_xwin) begin
        allowed = 1'b0;
      end
    end else begin
      allowed = paddr > TEST_ROM_LAST || mode_eff == MODE_BOOT || mode_eff == MODE_TEST;
    end
  end

  assign sfr_wr = taken && allowed && REQ_I.is_sfr && REQ_I.kind == ACC_WRITE;
  assign mode_wr = sfr_wr && REQ_I.group == GRP_SYS_MGMT && idx == IDX_MODE;

  // Target valid only for granted accesses; write, is_sfr, paddr and wdata follow the request every cycle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TGT_O <= '0;
      FAULT_O <= 1'b0;
    end else begin
      TGT_O.valid <= taken && allowed;
      TGT_O.write <= REQ_I.kind == ACC_WRITE;
      TGT_O.is_sfr <= REQ_I.is_sfr;
      TGT_O.paddr <= paddr;
      TGT_O.wdata <= REQ_I.wdata;
      FAULT_O <= taken && !allowed;
    end
  end

  // Mode selection and code segment tracking
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_reg <= MODE_BOOT;
      exec_seg_reg <= '0;
      copy_mode_reg <= MODE_USER;
      copy_seg_reg <= '0;
    end else begin
      if (mode_wr && REQ_I.wdata <= 8'(MODE_USER)) begin
        mode_reg <= mode_type'(REQ_I.wdata[2:0]);
      end
      if (taken && allowed && xlate && !REQ_I.copier && REQ_I.kind == ACC_FETCH) begin
        exec_seg_reg <= seg_idx;
      end
      if (COPY_CFG_I) begin
        copy_mode_reg <= mode_reg;
        copy_seg_reg <= exec_seg_reg;
      end
    end
  end

  // Firewall registers: boot flow is the only writer
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fw_ctrl_reg <= '0;
      xbase_reg <= '0;
      xsize_reg <= '0;
    end else if (sfr_wr && REQ_I.group == GRP_FW_WALL) begin
      unique case (idx)
        IDX_FW_CTRL_LOW: fw_ctrl_reg[7:0] <= REQ_I.wdata;
        IDX_FW_CTRL_HIGH: fw_ctrl_reg[15:8] <= REQ_I.wdata;
        IDX_XBASE_LOW: xbase_reg[7:0] <= REQ_I.wdata;
        IDX_XBASE_HIGH: xbase_reg[15:8] <= REQ_I.wdata;
        IDX_XSIZE_LOW: xsize_reg[7:0] <= REQ_I.wdata;
        IDX_XSIZE_HIGH: xsize_reg[15:8] <= REQ_I.wdata;
        default: ;
      endcase
    end
  end

  // Banked CPU registers: index 0 acc, 1 sp, 2 dptr, 3 watch exception
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bank_reg <= '{default: '0};
      RDATA_O <= '0;
    end else if (taken && allowed && REQ_I.is_sfr && REQ_I.group == GRP_CPU_GEN) begin
      if (REQ_I.kind == ACC_WRITE) begin
        bank_reg[mode_eff == MODE_USER][idx[1:0]] <= REQ_I.wdata;
      end
      RDATA_O <= bank_reg[mode_eff == MODE_USER][idx[1:0]];
    end
  end

  assign refresh_go = sfr_wr && REQ_I.group == GRP_SEG_CFG && idx == IDX_SEG_NUM;

  // Table pointer and count; writing the count reloads the table
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tbl_ptr_reg <= '0;
      seg_num_reg <= '0;
    end else if (sfr_wr && REQ_I.group == GRP_SEG_CFG) begin
      if (idx == IDX_PTR_LOW) begin
        tbl_ptr_reg[7:0] <= REQ_I.wdata;
      end
      if (idx == IDX_PTR_HIGH) begin
        tbl_ptr_reg[15:8] <= REQ_I.wdata;
      end
      if (idx == IDX_SEG_NUM) begin
        seg_num_reg <= (REQ_I.wdata > 8'(SEG_COUNT)) ?
                       (SEG_W+1)'(SEG_COUNT) : REQ_I.wdata[SEG_W:0];
      end
    end
  end

  assign TBL_REQ_O = state_reg == ST_FETCH;

  // Reload clears every entry and fetches only the defined ones
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg <= ST_IDLE;
      fill_idx_reg <= '0;
      TBL_ADDR_O <= '0;
      seg_table <= '{default: '0};
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (refresh_go) begin
            seg_table <= '{default: '0};
            fill_idx_reg <= '0;
            TBL_ADDR_O <= tbl_ptr_reg;
            if (REQ_I.wdata != 8'h00) begin
              state_reg <= ST_FETCH;
            end
          end
        end
        ST_FETCH: state_reg <= ST_WAIT;
        ST_WAIT: begin
          if (TBL_VALID_I) begin
            seg_table[fill_idx_reg[SEG_W-1:0]] <=
              seg_entry_type'(TBL_DATA_I[$bits(seg_entry_type)-1:0]);
            fill_idx_reg <= fill_idx_reg + 1'b1;
            TBL_ADDR_O <= TBL_ADDR_O + 1'b1;
            state_reg <= (fill_idx_reg + 1'b1 >= seg_num_reg) ? ST_IDLE : ST_FETCH;
          end
        end
      endcase
    end
  end

  AST_DENY_FAULT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    taken && !allowed |=> FAULT_O && !TGT_O.valid)
    else $error("refused access not faulted");
  AST_GRANT_PASS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    taken && allowed |=> TGT_O.valid && !FAULT_O && TGT_O.paddr == $past(paddr))
    else $error("granted access not passed");
  AST_NO_HIT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    taken && xlate && hit_vec == '0 |=> FAULT_O)
    else $error("unmapped address not refused");
  AST_EXEC_RIGHT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    taken && xlate && REQ_I.kind == ACC_FETCH && seg_hit && !seg_table[seg_idx].ex
    |=> FAULT_O)
    else $error("fetch without execute right");
  AST_FW_HIDDEN: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    TGT_O.valid && !TGT_O.is_sfr && $past(xlate) &&
    TGT_O.paddr >= FW_EE_FIRST && TGT_O.paddr <= FW_EE_LAST |-> 1'b0)
    else $error("application reached firmware memory");
  AST_TEST_SFR: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    taken && REQ_I.is_sfr && REQ_I.group == GRP_TEST && mode_eff == MODE_USER
    |=> FAULT_O)
    else $error("user reached test register");
  AST_MODE_LEGAL: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    mode_reg <= MODE_USER && ($stable(mode_reg) || $past(mode_wr)))
    else $error("mode changed without a write");
  AST_BUSY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    state_reg == ST_FETCH |-> !REQ_READY_O && TBL_REQ_O ##1 state_reg == ST_WAIT)
    else $error("table fetch sequence broken");
  AST_DISABLED: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    hit_vec[0] |-> seg_table[0].rw || seg_table[0].ex)
    else $error("disabled segment matched");
endmodule : mode_based_memory_access_guard

// ==== verilog/segment_match.sv ====
// One segment table entry: range match, rights and relocation
module segment_match (
  input wire guard_pkg::seg_entry_type entry_i,
  input wire logic [guard_pkg::ADDR_W-1:0] vaddr_i,
  input wire logic fetch_i,
  output logic hit_o,
  output logic ok_o,
  output logic [guard_pkg::ADDR_W-1:0] paddr_o
);
  import guard_pkg::*;
  logic enabled;
  // No rights at all means the entry takes no part in matching
  assign enabled = entry_i.rw | entry_i.ex;
  assign hit_o = enabled && vaddr_i >= entry_i.first && vaddr_i <= entry_i.last;
  // Read and write share one right, execute has its own
  assign ok_o = fetch_i ? entry_i.ex : entry_i.rw;
  assign paddr_o = vaddr_i + entry_i.reloc;
endmodule : segment_match
